// File: hdl/filter_chain.sv
// Capture and playback digital filter chain with AXI4-Lite registers.
// Assumes ref_tick pulses at the reference rate; streams use valid/ready.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
module filter_chain #(
  parameter int FW = 4
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ref_tick,
  // AXI4-Lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Capture: converter in, serial out
  input  wire filt_pkg::frame_t  adc_data,
  output logic                   adc_strobe,
  output filt_pkg::frame_t       pcm_tx_data,
  output logic                   pcm_tx_valid,
  input  wire logic              pcm_tx_ready,
  // Playback: serial in, converter out
  input  wire filt_pkg::frame_t  pcm_rx_data,
  input  wire logic              pcm_rx_valid,
  output logic                   pcm_rx_ready,
  output filt_pkg::frame_t       dac_data,
  output logic                   dac_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] rate_ff;
  logic [31:0] ctrl_ff;
  logic [15:0] hpc_ff  [3];
  logic [15:0] dec_ff  [3];
  logic [15:0] efc_ff  [filt_pkg::EFC_WORDS];
  logic        aw_ok_ff, w_ok_ff;
  logic [7:0]  aw_ff;
  logic [31:0] wd_ff;
  logic        wr_go;
  logic        rx_ovf_ff;

  function automatic logic signed [15:0] mac3(
      input logic signed [15:0] x0, input logic signed [15:0] x1,
      input logic signed [15:0] y1, input logic [15:0] c0,
      input logic [15:0] c1, input logic [15:0] c2);
    logic signed [33:0] acc;
    acc = 34'(x0 * $signed(c0)) + 34'(x1 * $signed(c1))
        + 34'(y1 * $signed(c2));
    return acc[filt_pkg::COEF_FRAC +: 16];
  endfunction : mac3

  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
  assign wr_go         = aw_ok_ff && w_ok_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff     <= 1'b0;
      w_ok_ff      <= 1'b0;
      aw_ff        <= '0;
      wd_ff        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= filt_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        aw_ff    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wd_ff   <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_ff > filt_pkg::ADDR_EFC_END ||
                         aw_ff == filt_pkg::ADDR_STAT) ?
                        filt_pkg::AXI_SLVERR : filt_pkg::AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; coefficients accepted whatever the enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_ff <= filt_pkg::RATE_RST;
      ctrl_ff <= filt_pkg::CTRL_RST;
      for (int i = 0; i < 3; i++) begin
        hpc_ff[i] <= filt_pkg::COEF_RST;
        dec_ff[i] <= filt_pkg::COEF_RST;
      end
      for (int i = 0; i < filt_pkg::EFC_WORDS; i++) begin
        efc_ff[i] <= filt_pkg::COEF_RST;
      end
    end else if (wr_go) begin
      if (aw_ff == filt_pkg::ADDR_RATE) rate_ff <= wd_ff & 32'h0000_03ff;
      if (aw_ff == filt_pkg::ADDR_CTRL) ctrl_ff <= wd_ff & 32'h0000_00ff;
      for (int i = 0; i < 3; i++) begin
        if (aw_ff == filt_pkg::ADDR_HPC + 8'(i*4) && i < 2)
          hpc_ff[i] <= wd_ff[15:0];
        if (aw_ff == filt_pkg::ADDR_DEC + 8'(i*4) && i < 2)
          dec_ff[i] <= wd_ff[15:0];
      end
      for (int i = 0; i < filt_pkg::EFC_WORDS; i++) begin
        if (aw_ff == filt_pkg::ADDR_EFC + 8'(i*4))
          efc_ff[i] <= wd_ff[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= filt_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= filt_pkg::AXI_OKAY;
      s_axi_rdata  <= '0;
      case (s_axi_araddr)
        filt_pkg::ADDR_RATE: s_axi_rdata <= rate_ff;
        filt_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_ff;
        filt_pkg::ADDR_STAT: s_axi_rdata <= {30'h0, rx_ovf_ff,
                                             ctrl_ff[filt_pkg::CTRL_EFF_DAC]};
        8'h10: s_axi_rdata <= {16'h0, hpc_ff[0]};
        8'h14: s_axi_rdata <= {16'h0, hpc_ff[1]};
        8'h18: s_axi_rdata <= {16'h0, dec_ff[0]};
        8'h1c: s_axi_rdata <= {16'h0, dec_ff[1]};
        default: begin
          if (s_axi_araddr >= filt_pkg::ADDR_EFC &&
              s_axi_araddr < filt_pkg::ADDR_EFC_END) begin
            s_axi_rdata <= {16'h0, efc_ff[4'(s_axi_araddr[7:2] - 6'h08)]};
          end else begin
            s_axi_rresp <= filt_pkg::AXI_SLVERR;
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Sample rates
  logic play_tick;
  rate_gen #(.FW(FW)) u_cap_rate (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ref_tick (ref_tick),
    .factor   (rate_ff[filt_pkg::RATE_CAP_LO +: FW]),
    .dual     (rate_ff[filt_pkg::RATE_CAP_DUAL]),
    .strobe   (adc_strobe)
  );
  rate_gen #(.FW(FW)) u_play_rate (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ref_tick (ref_tick),
    .factor   (rate_ff[filt_pkg::RATE_PLAY_LO +: FW]),
    .dual     (rate_ff[filt_pkg::RATE_PLAY_DUAL]),
    .strobe   (play_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Filter state, one sample per strobe; index 0 left, 1 right
  logic [1:0]         hp_sel [2];
  logic signed [15:0] hx_ff [2], hy_ff [2];
  logic signed [15:0] hp_out [2];
  logic signed [15:0] cap_in [2], play_in [2];
  logic signed [15:0] e_in [2], e_mid [2], e_out [2];
  logic signed [15:0] e1x_ff [2], e1y_ff [2], e2x_ff [2], e2y_ff [2];
  logic signed [15:0] dx_ff [2], dy_ff [2], de_out [2];
  logic               eff_dac, eff_on, deemp_on, hp_prog;
  logic               play_go;
  filt_pkg::frame_t   play_frame, cap_frame;

  assign hp_sel[0] = ctrl_ff[filt_pkg::CTRL_HPL_LO +: 2];
  assign hp_sel[1] = ctrl_ff[filt_pkg::CTRL_HPR_LO +: 2];
  assign hp_prog   = ctrl_ff[filt_pkg::CTRL_HP_PROG];
  assign eff_on    = ctrl_ff[filt_pkg::CTRL_EFF_EN];
  assign eff_dac   = ctrl_ff[filt_pkg::CTRL_EFF_DAC];
  assign deemp_on  = ctrl_ff[filt_pkg::CTRL_DEEMP_EN];
  assign cap_in[0]  = adc_data.left;
  assign cap_in[1]  = adc_data.right;
  assign play_in[0] = play_frame.left;
  assign play_in[1] = play_frame.right;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Standard corners: y = x - x1 + y1*(1 - 2^-k), k by selector
      case (hp_sel[c])
        2'd0:    hp_out[c] = cap_in[c];
        2'd1:    hp_out[c] = 16'(cap_in[c] - hx_ff[c] + hy_ff[c]
                                 - (hy_ff[c] >>> 10));
        2'd2:    hp_out[c] = 16'(cap_in[c] - hx_ff[c] + hy_ff[c]
                                 - (hy_ff[c] >>> 8));
        default: hp_out[c] = 16'(cap_in[c] - hx_ff[c] + hy_ff[c]
                                 - (hy_ff[c] >>> 6));
      endcase
      // Programmable mode overrides the fixed corners
      if (hp_prog && hp_sel[c] != 2'd0) begin
        hp_out[c] = mac3(cap_in[c], hx_ff[c], hy_ff[c],
                         hpc_ff[0], 16'(-hpc_ff[0]), hpc_ff[1]);
      end
      // Effects input from one path only
      e_in[c]  = eff_dac ? play_in[c] : hp_out[c];
      e_mid[c] = mac3(e_in[c], e1x_ff[c], e1y_ff[c],
                      efc_ff[0], efc_ff[1], efc_ff[3]);
      e_out[c] = mac3(e_mid[c], e2x_ff[c], e2y_ff[c],
                      efc_ff[5], efc_ff[6], efc_ff[8]);
      de_out[c] = mac3((eff_on && eff_dac) ? e_out[c] : play_in[c],
                       dx_ff[c], dy_ff[c],
                       dec_ff[0], dec_ff[1], dec_ff[2]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 2; c++) begin
        hx_ff[c] <= '0;  hy_ff[c] <= '0;
      end
    end else if (adc_strobe) begin
      for (int c = 0; c < 2; c++) begin
        hx_ff[c] <= cap_in[c];
        hy_ff[c] <= hp_out[c];
      end
    end
  end

  // Effects history advances on the attached path's strobe only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 2; c++) begin
        e1x_ff[c] <= '0; e1y_ff[c] <= '0; e2x_ff[c] <= '0; e2y_ff[c] <= '0;
      end
    end else if (eff_dac ? play_go : adc_strobe) begin
      for (int c = 0; c < 2; c++) begin
        e1x_ff[c] <= e_in[c];  e1y_ff[c] <= e_mid[c];
        e2x_ff[c] <= e_mid[c]; e2y_ff[c] <= e_out[c];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 2; c++) begin
        dx_ff[c] <= '0; dy_ff[c] <= '0;
      end
    end else if (play_go) begin
      for (int c = 0; c < 2; c++) begin
        dx_ff[c] <= (eff_on && eff_dac) ? e_out[c] : play_in[c];
        dy_ff[c] <= de_out[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture output through the buffer
  logic cap_ready;
  assign cap_frame.left  = (eff_on && !eff_dac) ? e_out[0] : hp_out[0];
  assign cap_frame.right = (eff_on && !eff_dac) ? e_out[1] : hp_out[1];
  skid_buf #(.DEPTH(2), .WIDTH($bits(filt_pkg::frame_t))) u_cap_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (adc_strobe),
    .in_ready  (cap_ready),
    .in_data   (cap_frame),
    .out_valid (pcm_tx_valid),
    .out_ready (pcm_tx_ready),
    .out_data  (pcm_tx_data)
  );

  // Playback input buffered; DAC pulls one frame per strobe
  logic play_valid;
  assign play_go = play_tick & play_valid;
  skid_buf #(.DEPTH(2), .WIDTH($bits(filt_pkg::frame_t))) u_play_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (pcm_rx_valid),
    .in_ready  (pcm_rx_ready),
    .in_data   (pcm_rx_data),
    .out_valid (play_valid),
    .out_ready (play_tick),
    .out_data  (play_frame)
  );

  // Capture overrun flag, sticky, cleared by a control write unless an overrun sets it in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ovf_ff <= 1'b0;
    end else if (adc_strobe && !cap_ready) begin
      rx_ovf_ff <= 1'b1;
    end else if (wr_go && aw_ff == filt_pkg::ADDR_CTRL) begin
      rx_ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_data   <= '0;
      dac_strobe <= 1'b0;
    end else begin
      dac_strobe <= play_go;
      if (play_go) begin
        dac_data.left  <= deemp_on ? de_out[0] :
                          ((eff_on && eff_dac) ? e_out[0] : play_in[0]);
        dac_data.right <= deemp_on ? de_out[1] :
                          ((eff_on && eff_dac) ? e_out[1] : play_in[1]);
      end
    end
  end

endmodule : filter_chain

// File: hdl/filt_pkg.sv
// Shared constants, register map and carrier types for the filter chain.
// Assumes a 32-bit AXI4-Lite register bus and 16-bit two-channel samples.
package filt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_RATE  = 8'h00;
  localparam logic [7:0] ADDR_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_HPC   = 8'h10;
  localparam logic [7:0] ADDR_DEC   = 8'h18;
  localparam logic [7:0] ADDR_EFC   = 8'h20;
  localparam logic [7:0] ADDR_EFC_END = 8'h48;

  ////////////////////////////////////////////////////////////////////////////
  // Control and rate field positions
  localparam int CTRL_HPL_LO   = 0;
  localparam int CTRL_HPR_LO   = 2;
  localparam int CTRL_HP_PROG  = 4;
  localparam int CTRL_EFF_EN   = 5;
  localparam int CTRL_EFF_DAC  = 6;
  localparam int CTRL_DEEMP_EN = 7;
  localparam int RATE_CAP_LO   = 0;
  localparam int RATE_PLAY_LO  = 4;
  localparam int RATE_CAP_DUAL = 8;
  localparam int RATE_PLAY_DUAL = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] COEF_RST = 16'h0000;
  localparam logic [15:0] UNITY    = 16'h4000;
  localparam int          COEF_FRAC = 14;
  localparam int          EFC_WORDS = 10;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } frame_t;

  typedef struct packed {
    logic [15:0] b0;
    logic [15:0] b1;
    logic [15:0] b2;
    logic [15:0] a1;
    logic [15:0] a2;
  } biquad_coef_t;

endpackage : filt_pkg

// File: hdl/skid_buf.sv
// Two-entry valid/ready buffer for stereo frames.
// Assumes one clock; the drain side may stall at any time.
module skid_buf #(
  parameter int DEPTH = 2,
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0]       mem [DEPTH];
  logic [$clog2(DEPTH):0] cnt_ff;
  logic [$clog2(DEPTH)-1:0] wp_ff;
  logic [$clog2(DEPTH)-1:0] rp_ff;
  logic                   push;
  logic                   pop;

  assign in_ready  = (cnt_ff != ($clog2(DEPTH)+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      wp_ff  <= '0;
      rp_ff  <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + ($clog2(DEPTH)+1)'(push) - ($clog2(DEPTH)+1)'(pop);
    end
  end

endmodule : skid_buf

// File: hdl/rate_gen.sv
// Sample strobe generator: divides the reference-rate tick by a factor.
// Assumes ref_tick is a one-cycle pulse at the reference sample rate.
module rate_gen #(
  parameter int FW = 4
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Control
  input  wire logic          ref_tick,
  input  wire logic [FW-1:0] factor,
  input  wire logic          dual,
  // Strobe
  output logic               strobe
);

  logic [FW:0] cnt_ff;
  logic [FW:0] limit;
  logic [1:0]  dual_ph_ff;
  logic        fire;

  // Factor code n divides by n+1 (factor 0 gives the reference rate)
  assign limit = {1'b0, factor};
  assign fire  = ref_tick & (cnt_ff >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (fire) begin
      cnt_ff <= '0;
    end else if (ref_tick) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Dual rate: an extra strobe two cycles later doubles the output rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dual_ph_ff <= '0;
    end else begin
      dual_ph_ff <= {dual_ph_ff[0], dual & fire};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe <= 1'b0;
    end else begin
      strobe <= fire | dual_ph_ff[1];
    end
  end

endmodule : rate_gen

// File: sim/filter_chain_assertions.sv
// Checker for the filter chain port timing.
// Assumes it is bound onto filter_chain and sees its ports only.
module filter_chain_checker #(
  parameter int FW = 4
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             ref_tick,
  // Register bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  // Streams
  input wire logic             adc_strobe,
  input wire filt_pkg::frame_t pcm_tx_data,
  input wire logic             pcm_tx_valid,
  input wire logic             pcm_tx_ready,
  input wire filt_pkg::frame_t dac_data,
  input wire logic             dac_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cap_cause: assert property (
    adc_strobe |-> $past(ref_tick) || $past(ref_tick, 3))
    else $error("capture strobe without reference tick");
  a_cap_push: assert property (
    adc_strobe |=> pcm_tx_valid)
    else $error("captured frame not offered");
  a_tx_hold: assert property (
    pcm_tx_valid && !pcm_tx_ready |=> pcm_tx_valid && $stable(pcm_tx_data))
    else $error("stalled capture frame changed");
  a_dac_stable: assert property (
    !dac_strobe |-> $stable(dac_data))
    else $error("converter data moved without strobe");
  a_dac_pulse: assert property (
    dac_strobe |=> !dac_strobe)
    else $error("converter strobe longer than a cycle");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_wr_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");

  c_cap: cover property (adc_strobe ##1 pcm_tx_valid && pcm_tx_ready);
  c_dac: cover property (dac_strobe);
  c_stall: cover property (pcm_tx_valid && !pcm_tx_ready);
endmodule : filter_chain_checker

bind filter_chain filter_chain_checker #(.FW(FW)) filter_chain_checker_inst (.*);

// File: sim/pcm_host_model.sv
// Host audio processor on the serial side: sends and collects frames.
// Assumes the bench fills send_q and reads got_q hierarchically.
module pcm_host_model (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Stall request
  input  wire logic             stall,
  // Capture stream in
  input  wire filt_pkg::frame_t pcm_tx_data,
  input  wire logic             pcm_tx_valid,
  output logic                  pcm_tx_ready,
  // Playback stream out
  output filt_pkg::frame_t      pcm_rx_data,
  output logic                  pcm_rx_valid,
  input  wire logic             pcm_rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  filt_pkg::frame_t send_q[$];
  filt_pkg::frame_t got_q[$];

  initial begin
    pcm_tx_ready = 1'b1;
    pcm_rx_valid = 1'b0;
    pcm_rx_data = '0;
  end

  always @(posedge aclk) begin
    if (pcm_tx_valid && pcm_tx_ready) begin
      got_q.push_back(pcm_tx_data);
    end
    pcm_tx_ready <= !stall;
    if (!aresetn) begin
      pcm_rx_valid <= 1'b0;
    end else if (!pcm_rx_valid || pcm_rx_ready) begin
      if (send_q.size() > 0) begin
        pcm_rx_valid <= 1'b1;
        pcm_rx_data <= send_q.pop_front();
      end else begin
        // Idle line toggles so no stale frame looks valid
        pcm_rx_valid <= 1'b0;
        pcm_rx_data <= ~pcm_rx_data;
      end
    end
  end
endmodule : pcm_host_model

// File: sim/tb_filter_chain.sv
// Self-checking bench for the filter chain.
// Assumes the checker is bound and the host model sits on the streams.
module tb_filter_chain;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, ref_tick, stall;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, adc_strobe, dac_strobe;
  logic pcm_tx_valid, pcm_tx_ready, pcm_rx_valid, pcm_rx_ready;
  filt_pkg::frame_t adc_data, pcm_tx_data, pcm_rx_data, dac_data;
  filt_pkg::frame_t cap_q[$], dac_q[$], sent_q[$];
  logic [2:0] tk;
  logic [7:0] seq, pseq;
  int err_total, checks_done, adc_cnt, dac_cnt;

  filter_chain #(.FW(4)) filter_chain_inst (.*);
  pcm_host_model pcm_host_model_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic filt_pkg::frame_t mk(input logic [7:0] s);
    mk.left = {4'h0, s, 4'h0};
    mk.right = 16'h0000 - mk.left;
  endfunction : mk

  function automatic filt_pkg::frame_t sc(input filt_pkg::frame_t f,
                                          input int sh);
    sc.left = 16'($signed(f.left) >>> sh);
    sc.right = 16'($signed(f.right) >>> sh);
  endfunction : sc

  // Reference tick every 8 cycles; converter samples change per strobe
  always @(posedge aclk) begin
    tk <= tk + 3'h1;
    ref_tick <= (tk == 3'h7);
    if (adc_strobe) begin
      cap_q.push_back(adc_data);
      adc_cnt++;
      seq <= seq + 8'h01;
      adc_data <= mk(seq);
    end
    if (dac_strobe) begin
      dac_q.push_back(dac_data);
      dac_cnt++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        chk(32'(r), 32'(er));
        return;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ev,
                    input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        chk(d, ev);
        chk(32'(r), 32'(er));
        return;
      end
    end
  endtask : rd

  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      pcm_host_model_inst.send_q.push_back(mk(pseq));
      sent_q.push_back(mk(pseq));
      pseq++;
    end
  endtask : feed

  task automatic rates(input int ec, input int ed);
    repeat (64) @(posedge aclk);
    @(negedge aclk);
    adc_cnt = 0;
    dac_cnt = 0;
    repeat (384) @(negedge aclk);
    chk(32'(adc_cnt), 32'(ec));
    chk(32'(dac_cnt), 32'(ed));
    @(posedge aclk);
  endtask : rates

  // Drain, align both streams, then compare against scaled inputs
  task automatic run(input int shc, input int shp, input bit ronly);
    filt_pkg::frame_t e;
    for (int n = 0; n < 3000; n++) begin
      if (pcm_host_model_inst.send_q.size() == 0) break;
      @(posedge aclk);
    end
    repeat (80) @(posedge aclk);
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      if (adc_strobe) break;
    end
    repeat (3) @(posedge aclk);
    cap_q.delete();
    dac_q.delete();
    sent_q.delete();
    pcm_host_model_inst.got_q.delete();
    feed(6);
    repeat (240) @(posedge aclk);
    chk(32'(pcm_host_model_inst.got_q.size() > 4), 32'h1);
    foreach (pcm_host_model_inst.got_q[i]) begin
      e = sc(cap_q[i], shc);
      if (ronly) chk(32'(pcm_host_model_inst.got_q[i].right), 32'(e.right));
      else chk(pcm_host_model_inst.got_q[i], e);
    end
    chk(32'(dac_q.size()), 32'h6);
    foreach (dac_q[i]) chk(dac_q[i], sc(sent_q[i], shp));
  endtask : run

  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, ref_tick, stall, tk, seq, pseq} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_data} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = '1;
    {err_total, checks_done, adc_cnt, dac_cnt} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(filt_pkg::ADDR_RATE, filt_pkg::RATE_RST, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_CTRL, filt_pkg::CTRL_RST, filt_pkg::AXI_OKAY);
    rd(8'h0c, 32'h0, filt_pkg::AXI_SLVERR);
    wr(filt_pkg::ADDR_STAT, 32'h1, filt_pkg::AXI_SLVERR);
    feed(120);
    wr(filt_pkg::ADDR_RATE, 32'h0000_0012, filt_pkg::AXI_OKAY);
    rates(16, 24);
    wr(filt_pkg::ADDR_RATE, 32'h0000_0312, filt_pkg::AXI_OKAY);
    rates(32, 48);
    wr(filt_pkg::ADDR_RATE, 32'h0000_0012, filt_pkg::AXI_OKAY);
    run(0, 0, 0);
    // Effects at half gain per section, loaded while disabled
    wr(filt_pkg::ADDR_EFC, 32'h2000, filt_pkg::AXI_OKAY);
    wr(filt_pkg::ADDR_EFC + 8'h14, 32'h2000, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_EFC, 32'h2000, filt_pkg::AXI_OKAY);
    wr(filt_pkg::ADDR_CTRL, 32'h20, filt_pkg::AXI_OKAY);
    run(2, 0, 0);
    wr(filt_pkg::ADDR_DEC, 32'h2000, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_DEC, 32'h2000, filt_pkg::AXI_OKAY);
    wr(filt_pkg::ADDR_CTRL, 32'he0, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_STAT, 32'h1, filt_pkg::AXI_OKAY);
    run(0, 3, 0);
    wr(filt_pkg::ADDR_EFC, 32'h4000, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_EFC, 32'h4000, filt_pkg::AXI_OKAY);
    run(0, 2, 0);
    for (int s = 0; s < 4; s++) begin
      wr(filt_pkg::ADDR_CTRL, 32'(s * 5), filt_pkg::AXI_OKAY);
      rd(filt_pkg::ADDR_CTRL, 32'(s * 5), filt_pkg::AXI_OKAY);
    end
    wr(filt_pkg::ADDR_CTRL, 32'h01, filt_pkg::AXI_OKAY);
    run(0, 0, 1);
    wr(filt_pkg::ADDR_HPC, 32'h4000, filt_pkg::AXI_OKAY);
    wr(filt_pkg::ADDR_HPC + 8'h04, 32'h0123, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_HPC + 8'h04, 32'h0123, filt_pkg::AXI_OKAY);
    wr(filt_pkg::ADDR_CTRL, 32'h10, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_CTRL, 32'h10, filt_pkg::AXI_OKAY);
    // Host stall fills the capture buffer and forces drops
    stall <= 1'b1;
    repeat (150) @(posedge aclk);
    rd(filt_pkg::ADDR_STAT, 32'h2, filt_pkg::AXI_OKAY);
    stall <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(filt_pkg::ADDR_CTRL, 32'h0, filt_pkg::AXI_OKAY);
    rd(filt_pkg::ADDR_STAT, 32'h0, filt_pkg::AXI_OKAY);
    finish_test();
  end
endmodule : tb_filter_chain
